/* rtl/lpc_pkg.sv */
// constants and types for the line phase comparison logic
`default_nettype none
package lpc_pkg;
  // clock rate and the microsecond enable tick
  localparam int unsigned CLK_MHZ     = 100;
  localparam int unsigned TICK_NS     = 1000;
  localparam int unsigned TICK_CYCLES = TICK_NS * CLK_MHZ / 1000;
  // trip extension after pickup
  localparam int unsigned EXT_MS      = 18;
  localparam int unsigned EXT_US      = EXT_MS * 1000;
  // default integrator pickup, the stability angle setting
  localparam int unsigned PICKUP_MS   = 3;
  localparam int unsigned PICKUP_US   = PICKUP_MS * 1000;

  localparam int unsigned DIV_W  = 16;
  localparam int unsigned CNT_W  = 16;
  localparam int unsigned N_REM  = 2;

  // register byte offsets
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_PICKUP = 8'h04;
  localparam logic [7:0] ADDR_THRESH = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0c;

  // control word, bit 0 is enable
  typedef struct packed {
    logic three_term;
    logic neg_cmp;
    logic invert;
    logic form_b;
    logic block;
    logic onoff;
    logic enable;
  } lpc_ctrl_s;

  // status word, bit 0 is trip
  typedef struct packed {
    logic [N_REM-1:0] rx_lo;
    logic [N_REM-1:0] rx_hi;
    logic             fault_detector_high_set;
    logic             coincide;
    logic             local_neg;
    logic             local_pos;
    logic             tx_key;
    logic             trip;
  } lpc_status_s;

  localparam int unsigned CTRL_W     = $bits(lpc_ctrl_s);
  localparam lpc_ctrl_s   CTRL_RST   = '0;
  localparam logic [15:0] PICKUP_RST = 16'h0bb8;
  localparam logic [15:0] THRESH_RST = 16'h0040;
endpackage : lpc_pkg
`default_nettype wire

/* rtl/lpc_comparer.sv */
// single-phase comparison trip logic with register port
//
// Implementation choices: the address map and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module lpc_comparer
  import lpc_pkg::*;
#(
  parameter int unsigned P_TICK_CYCLES = TICK_CYCLES,
  parameter int unsigned P_EXT_US      = EXT_US
)(
  input  wire logic                i_clk_sys,
  input  wire logic                i_rst,
  input  wire logic [7:0]          i_addr,
  input  wire logic [31:0]         i_wdata,
  input  wire logic                i_wr,
  input  wire logic                i_rd,
  output var  logic [31:0]         o_rdata,
  input  wire logic signed [15:0]  i_cur_a,
  input  wire logic signed [15:0]  i_cur_b,
  input  wire logic signed [15:0]  i_cur_c,
  input  wire logic                i_fdh,
  input  wire logic                i_fdl,
  input  wire logic [N_REM-1:0]    i_rx_hi,
  input  wire logic [N_REM-1:0]    i_rx_lo,
  output var  logic                o_tx_key,
  output var  logic                o_trip
);

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction : hit

  lpc_ctrl_s          ctrl;
  lpc_status_s        status;
  logic [15:0]        pickup_us;
  logic [15:0]        thresh;
  logic [N_REM-1:0]   rx_hi_m;
  logic [N_REM-1:0]   rx_hi_s;
  logic [N_REM-1:0]   rx_lo_m;
  logic [N_REM-1:0]   rx_lo_s;
  logic [DIV_W-1:0]   div_cnt;
  logic               tick;
  logic signed [17:0] mixed;
  logic signed [17:0] thr_s;
  logic               local_pos;
  logic               local_neg;
  logic               local_half;
  logic [N_REM-1:0]   mark;
  logic [N_REM-1:0]   space;
  logic [N_REM-1:0]   present;
  logic [N_REM-1:0]   gate_ok;
  logic               coincide;
  logic [CNT_W-1:0]   integ_cnt;
  logic [CNT_W-1:0]   ext_cnt;
  logic               pickup_hit;

  // channel receivers are asynchronous to us
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      rx_hi_m <= '0;
      rx_hi_s <= '0;
      rx_lo_m <= '0;
      rx_lo_s <= '0;
    end
    else
    begin
      rx_hi_m <= i_rx_hi;
      rx_hi_s <= rx_hi_m;
      rx_lo_m <= i_rx_lo;
      rx_lo_s <= rx_lo_m;
    end
  end

  // register writes
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      ctrl      <= CTRL_RST;
      pickup_us <= PICKUP_RST;
      thresh    <= THRESH_RST;
    end
    else if (i_wr)
    begin
      if (hit(i_addr, ADDR_CTRL))
        ctrl <= lpc_ctrl_s'(i_wdata[CTRL_W-1:0]);
      if (hit(i_addr, ADDR_PICKUP))
        pickup_us <= i_wdata[15:0];
      if (hit(i_addr, ADDR_THRESH))
        thresh <= i_wdata[15:0];
    end
  end

  // read data stand one cycle only, unmapped reads give zero
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
      o_rdata <= '0;
    else if (i_rd && hit(i_addr, ADDR_CTRL))
      o_rdata <= 32'(ctrl);
    else if (i_rd && hit(i_addr, ADDR_PICKUP))
      o_rdata <= 32'(pickup_us);
    else if (i_rd && hit(i_addr, ADDR_THRESH))
      o_rdata <= 32'(thresh);
    else if (i_rd && hit(i_addr, ADDR_STATUS))
      o_rdata <= 32'(status);
    else
      o_rdata <= '0;
  end

  // microsecond enable
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      div_cnt <= '0;
      tick    <= 1'b0;
    end
    else if (div_cnt == DIV_W'(P_TICK_CYCLES - 1))
    begin
      div_cnt <= '0;
      tick    <= 1'b1;
    end
    else
    begin
      div_cnt <= div_cnt + 1'b1;
      tick    <= 1'b0;
    end
  end

  // mixing network, 2a - b - c keeps balanced faults visible
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
      mixed <= '0;
    else
      mixed <= (18'(i_cur_a) <<< 1) - 18'(i_cur_b) - 18'(i_cur_c);
  end

  assign thr_s = $signed({2'b00, thresh});

  // polarity squarer; the dead band means "no current" near zero
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      local_pos <= 1'b0;
      local_neg <= 1'b0;
    end
    else
    begin
      local_pos <= mixed > thr_s;
      local_neg <= mixed < -thr_s;
    end
  end

  // choose which local half cycle is compared
  assign local_half = ctrl.neg_cmp ? local_neg : local_pos;

  for (genvar r = 0; r < N_REM; r++)
  begin : g_rem
    logic hi_sig;
    logic lo_sig;
    assign hi_sig = rx_hi_s[r];
    assign lo_sig = ctrl.onoff ? ~rx_hi_s[r] : rx_lo_s[r];
    // symbol meaning is independent of channel form
    assign mark[r]    = ctrl.invert ? lo_sig : hi_sig;
    assign space[r]   = ctrl.invert ? hi_sig : lo_sig;
    assign present[r] = hi_sig;
    // second remote counts only on three-terminal lines
    // blocking form needs no received signal
    // alternative form uses absence of the opposite symbol
    // antiphase remote never satisfies the unblocked gates
    assign gate_ok[r] = (r != 0 && !ctrl.three_term) ? 1'b1 :
                        ctrl.block  ? ~present[r] :
                        ctrl.form_b ? (ctrl.neg_cmp ? ~mark[r] : ~space[r]) :
                        (ctrl.neg_cmp ? space[r] : mark[r]);
  end

  // comparer armed only by the high-set detector
  // coincidence of local half with every remote gate
  assign coincide = ctrl.enable & i_fdh & local_half & (&gate_ok);

  // pickup count in microseconds sets the stability angle
  assign pickup_hit = coincide && (integ_cnt >= pickup_us);

  // integrator restarts on any break in coincidence
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
      integ_cnt <= '0;
    else if (!coincide)
      integ_cnt <= '0;
    else if (tick && integ_cnt != '1)
      integ_cnt <= integ_cnt + 1'b1;
  end

  // trip extension, retriggered at each pickup
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
      ext_cnt <= '0;
    else if (pickup_hit)
      ext_cnt <= CNT_W'(P_EXT_US);
    else if (tick && ext_cnt != '0)
      ext_cnt <= ext_cnt - 1'b1;
  end

  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
      o_trip <= 1'b0;
    else
      o_trip <= pickup_hit | (ext_cnt != '0);
  end

  // transmitter keying
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
      o_tx_key <= 1'b0;
    // blocking carrier from low-set, cut in local half
    else if (ctrl.block)
      o_tx_key <= ctrl.enable & i_fdl & ~local_half;
    // first state on positive, second on negative
    else
      o_tx_key <= ctrl.enable & (ctrl.invert ? local_neg : local_pos);
  end

  assign status.rx_lo     = rx_lo_s;
  assign status.rx_hi     = rx_hi_s;
  assign status.fault_detector_high_set       = i_fdh;
  assign status.coincide  = coincide;
  assign status.local_neg = local_neg;
  assign status.local_pos = local_pos;
  assign status.tx_key    = o_tx_key;
  assign status.trip      = o_trip;

  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_rst);

  sequence s_rd_status;
    i_rd && hit(i_addr, ADDR_STATUS);
  endsequence

  sequence s_pickup;
    pickup_hit;
  endsequence

  a_status_read: assert property (s_rd_status |=> o_rdata == 32'($past(status)))
    else $error("status read data wrong");
  a_read_idle: assert property (!i_rd |=> o_rdata == '0)
    else $error("read data outside read slot");
  a_integ_clear: assert property (!coincide |=> integ_cnt == '0)
    else $error("integrator not cleared");
  a_trip_cause: assert property ($rose(o_trip) |-> $past(pickup_hit))
    else $error("trip without pickup");
  a_ext_load: assert property (s_pickup |=> ext_cnt == CNT_W'(P_EXT_US) && o_trip)
    else $error("extension not loaded");
  a_trip_hold: assert property (ext_cnt != '0 |=> o_trip)
    else $error("trip dropped during extension");
  a_pickup_time: assert property ($rose(pickup_hit) && pickup_us != '0
                                  && $stable(pickup_us) |-> $past(coincide) && $past(tick))
    else $error("pickup before setting");
  a_fdh_gate: assert property (!i_fdh |=> integ_cnt == '0)
    else $error("comparer active without high-set");
  a_block_inhib: assert property (ctrl.block && present[0] |-> !coincide)
    else $error("blocking signal ignored");
  a_through_flt: assert property (!ctrl.block && !ctrl.form_b && !ctrl.neg_cmp
                                  && space[0] && !mark[0] |-> !coincide)
    else $error("coincidence on antiphase");
  a_three_term: assert property (ctrl.three_term && !gate_ok[1] |-> !coincide)
    else $error("second remote ignored");
  a_tx_key: assert property (!ctrl.block && ctrl.enable && !ctrl.invert
                             && local_pos |=> o_tx_key)
    else $error("transmitter not keyed");
  a_tx_block: assert property (ctrl.block && local_half |=> !o_tx_key)
    else $error("blocking carrier in local half");
  a_rx_sync: assert property (##2 rx_hi_s == $past(i_rx_hi, 2))
    else $error("receiver sync delay wrong");

  sequence s_coin_tick;
    coincide && tick && integ_cnt != '1;
  endsequence

  a_integ_step: assert property (s_coin_tick |=> integ_cnt == $past(integ_cnt) + 1'b1)
    else $error("integrator step wrong");
  a_ext_end: assert property (ext_cnt == '0 && !pickup_hit |=> !o_trip)
    else $error("trip held past extension");
  a_enable_gate: assert property (!ctrl.enable |-> !coincide)
    else $error("comparer active while disabled");
  a_tick_pulse: assert property (tick && P_TICK_CYCLES > 1 |=> !tick)
    else $error("tick longer than one cycle");
  a_mix_sign: assert property (i_cur_a > 16'sh0000 && i_cur_b == 16'sh0000
                               && i_cur_c == 16'sh0000 |=> mixed > 18'sh00000)
    else $error("mixed current sign wrong");
  a_mark_pos: assert property (!ctrl.invert && !ctrl.onoff
                               |-> mark == rx_hi_s && space == rx_lo_s)
    else $error("symbol decode wrong");
  a_inv_swap: assert property (ctrl.invert && !ctrl.onoff
                               |-> mark == rx_lo_s && space == rx_hi_s)
    else $error("inverted symbol decode wrong");
  a_onoff_sym: assert property (ctrl.onoff |-> (mark ^ space) == '1)
    else $error("on-off symbols not exclusive");
  a_form_b_gate: assert property (!ctrl.block && ctrl.form_b && !ctrl.neg_cmp
                                  && space[0] |-> !coincide)
    else $error("space ignored in alternative form");
  a_neg_gate: assert property (!ctrl.block && !ctrl.form_b && ctrl.neg_cmp
                               && !space[0] |-> !coincide)
    else $error("negative half gated without space");
  a_tx_inv: assert property (!ctrl.block && ctrl.enable && ctrl.invert
                             && local_neg |=> o_tx_key)
    else $error("inverted keying wrong");
  a_tx_fdl: assert property (ctrl.block && ctrl.enable && i_fdl
                             && !local_half |=> o_tx_key)
    else $error("blocking carrier not keyed");

endmodule : lpc_comparer
`default_nettype wire

/* verif/lpc_remote.sv */
// behavioural remote terminal keying its channel
`timescale 1ns/1ps
`default_nettype none
module lpc_remote (
  input  wire logic i_clk_sys,
  input  wire logic i_act,
  input  wire logic i_pos,
  input  wire logic i_inv,
  output var  logic o_rx_hi,
  output var  logic o_rx_lo
);
  // half cycle keys tone
  // silent channel drives neither tone
  always_ff @(posedge i_clk_sys)
  begin
    o_rx_hi <= i_act & (i_inv ? ~i_pos : i_pos);
    o_rx_lo <= i_act & (i_inv ? i_pos : ~i_pos);
  end
endmodule : lpc_remote
`default_nettype wire

/* verif/line_phase_comparison_logic_bench.sv */
// self-checking bench for the comparison trip logic
`timescale 1ns/1ps
`default_nettype none
module line_phase_comparison_logic_bench;
  import lpc_pkg::*;
  logic               i_clk_sys, i_rst, i_wr, i_rd, i_fdh, i_fdl, o_tx_key, o_trip;
  logic [7:0]         i_addr;
  logic [31:0]        i_wdata, o_rdata, d;
  logic signed [15:0] i_cur_a, i_cur_b, i_cur_c;
  wire logic [N_REM-1:0] i_rx_hi, i_rx_lo;
  logic [N_REM-1:0]   r_pos;
  logic               r_act, r_inv;
  int                 n_fail, total_checks;

  lpc_comparer #(.P_TICK_CYCLES(2), .P_EXT_US(20)) u_dut (.i_clk_sys(i_clk_sys),
    .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .i_cur_a(i_cur_a), .i_cur_b(i_cur_b), .i_cur_c(i_cur_c),
    .i_fdh(i_fdh), .i_fdl(i_fdl), .i_rx_hi(i_rx_hi), .i_rx_lo(i_rx_lo),
    .o_tx_key(o_tx_key), .o_trip(o_trip));
  lpc_remote u_rem1 (.i_clk_sys(i_clk_sys), .i_act(r_act), .i_pos(r_pos[0]),
    .i_inv(r_inv), .o_rx_hi(i_rx_hi[0]), .o_rx_lo(i_rx_lo[0]));
  lpc_remote u_rem2 (.i_clk_sys(i_clk_sys), .i_act(r_act), .i_pos(r_pos[1]),
    .i_inv(r_inv), .o_rx_hi(i_rx_hi[1]), .o_rx_lo(i_rx_lo[1]));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    total_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge i_clk_sys);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= v;
    @(posedge i_clk_sys);
    i_wr    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge i_clk_sys);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_clk_sys);
    i_rd   <= 1'b0;
    #1 v = o_rdata;
  endtask : rd

  task automatic quiet();
    i_fdh   <= 1'b0;
    r_act   <= 1'b0;
    i_cur_a <= 16'sh0000;
    i_cur_b <= 16'sh0000;
  endtask : quiet

  task automatic t_regs();
    rd(ADDR_CTRL, d);
    chk(d, 32'h0000_0000, "ctrl reset");
    rd(ADDR_PICKUP, d);
    chk(d, 32'h0000_0bb8, "pickup reset");
    rd(ADDR_THRESH, d);
    chk(d, 32'h0000_0040, "thresh reset");
    wr(8'h10, 32'hffff_ffff);
    rd(8'h10, d);
    chk(d, 32'h0000_0000, "unmapped read");
    // short pickup of 5 ticks keeps runs brief
    wr(ADDR_PICKUP, 32'h0000_0005);
    rd(ADDR_PICKUP, d);
    chk(d, 32'h0000_0005, "pickup write");
  endtask : t_regs

  // one fault case: trip seen, tx key, hold over, release
  task automatic run(input logic [6:0] c, input logic signed [15:0] a,
                     input logic signed [15:0] b, input logic [1:0] p,
                     input logic inv, input logic fh, input logic et, input logic ek);
    logic hit;
    hit = 1'b0;
    wr(ADDR_CTRL, {25'h0, c});
    i_cur_a <= a;
    i_cur_b <= b;
    r_pos   <= p;
    r_inv   <= inv;
    r_act   <= 1'b1;
    i_fdh   <= fh;
    repeat (40)
    begin
      @(posedge i_clk_sys);
      #1 hit = hit | (o_trip === 1'b1);
    end
    chk(hit, et, "trip decision");
    chk(o_tx_key, ek, "tx key");
    rd(ADDR_STATUS, d);
    chk(d[0], et, "status trip");
    chk(d[1], ek, "status tx key");
    @(posedge i_clk_sys);
    quiet();
    repeat (20) @(posedge i_clk_sys);
    #1 chk(o_trip, et, "extension hold");
    repeat (50) @(posedge i_clk_sys);
    #1 chk(o_trip, 1'b0, "extension end");
  endtask : run

  // bursts shorter than pickup must never add up
  task automatic t_broken();
    logic hit;
    hit = 1'b0;
    wr(ADDR_CTRL, 32'h0000_0001);
    i_cur_a <= 16'sh0064;
    r_inv   <= 1'b0;
    r_act   <= 1'b1;
    i_fdh   <= 1'b1;
    repeat (8)
    begin
      r_pos <= 2'b11;
      repeat (6) @(posedge i_clk_sys);
      r_pos <= 2'b00;
      repeat (3)
      begin
        @(posedge i_clk_sys);
        #1 hit = hit | (o_trip === 1'b1);
      end
    end
    chk(hit, 1'b0, "broken coincidence");
    quiet();
    repeat (60) @(posedge i_clk_sys);
  endtask : t_broken

  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : results

  initial
  begin
    i_clk_sys = 1'b0;
    forever #5 i_clk_sys = ~i_clk_sys;
  end

  initial
  begin
    #200us;
    n_fail++;
    results();
  end

  initial
  begin
    {i_wr, i_rd, i_fdh, i_addr, i_wdata, i_cur_c, r_pos, r_inv} = '0;
    {i_cur_a, i_cur_b, r_act, n_fail, total_checks} = '0;
    i_fdl = 1'b1;
    i_rst = 1'b1;
    repeat (3) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    #1 chk(o_trip, 1'b0, "trip at reset");
    t_regs();
    run(7'h01, 16'sh0064, 16'sh0000, 2'b11, 1'b0, 1'b1, 1'b1, 1'b1);
    run(7'h01, 16'sh0064, 16'sh0000, 2'b00, 1'b0, 1'b1, 1'b0, 1'b1);
    run(7'h01, 16'sh0064, 16'sh0000, 2'b11, 1'b0, 1'b0, 1'b0, 1'b1);
    run(7'h00, 16'sh0064, 16'sh0000, 2'b11, 1'b0, 1'b1, 1'b0, 1'b0);
    run(7'h01, 16'sh0000, -16'sh0064, 2'b11, 1'b0, 1'b1, 1'b1, 1'b1);
    run(7'h09, 16'sh0064, 16'sh0000, 2'b11, 1'b0, 1'b1, 1'b1, 1'b1);
    run(7'h09, 16'sh0064, 16'sh0000, 2'b00, 1'b0, 1'b1, 1'b0, 1'b1);
    run(7'h11, 16'sh0064, 16'sh0000, 2'b11, 1'b1, 1'b1, 1'b1, 1'b0);
    run(7'h21, -16'sh0064, 16'sh0000, 2'b00, 1'b0, 1'b1, 1'b1, 1'b0);
    run(7'h21, -16'sh0064, 16'sh0000, 2'b11, 1'b0, 1'b1, 1'b0, 1'b0);
    run(7'h03, 16'sh0064, 16'sh0000, 2'b11, 1'b0, 1'b1, 1'b1, 1'b1);
    run(7'h07, 16'sh0064, 16'sh0000, 2'b11, 1'b1, 1'b1, 1'b1, 1'b0);
    run(7'h07, 16'sh0064, 16'sh0000, 2'b00, 1'b1, 1'b1, 1'b0, 1'b0);
    run(7'h07, 16'sh0000, 16'sh0000, 2'b00, 1'b1, 1'b1, 1'b0, 1'b1);
    i_fdl <= 1'b0;
    run(7'h07, 16'sh0000, 16'sh0000, 2'b00, 1'b1, 1'b1, 1'b0, 1'b0);
    i_fdl <= 1'b1;
    run(7'h01, 16'sh0064, 16'sh0000, 2'b01, 1'b0, 1'b1, 1'b1, 1'b1);
    run(7'h41, 16'sh0064, 16'sh0000, 2'b01, 1'b0, 1'b1, 1'b0, 1'b1);
    run(7'h41, 16'sh0064, 16'sh0000, 2'b11, 1'b0, 1'b1, 1'b1, 1'b1);
    t_broken();
    results();
  end
endmodule : line_phase_comparison_logic_bench
`default_nettype wire
